// *** shared/sector_guard_pkg.sv ***
// constants and types shared by the sector guard
// assumes a single clock domain and no bus other than the documented ports
package sector_guard_pkg;
   localparam int          SECTOR_COUNT      = 4;
   localparam int          BLOCK_ADDR_WIDTH  = 7;
   localparam int          BLOCKS_PER_SECTOR = 32;
   localparam int          SECTOR_SHIFT      = 5;
   localparam int          PASSWORD_WIDTH    = 32;
   // guard byte field positions
   localparam int          LOCK_BIT          = 0;
   localparam int          PROT_LSB          = 1;
   localparam int          LINK_LSB          = 3;
   localparam int          USED_BITS         = 5;
   // status byte word at system area byte address 0
   localparam logic [10:0] GUARD_BYTES_ADDR  = 11'h000;
   localparam logic [7:0]  GUARD_BYTE_RESET  = 8'h00;
   localparam logic [31:0] PASSWORD_RESET    = 32'h0000_0000;
   // protection codes
   localparam logic [1:0]  PROT_WR_PWD       = 2'h0;
   localparam logic [1:0]  PROT_OPEN         = 2'h1;
   localparam logic [1:0]  PROT_RW_PWD       = 2'h2;
   localparam logic [1:0]  PROT_RD_PWD       = 2'h3;
   localparam logic [1:0]  LINK_NONE         = 2'h0;

   typedef enum logic [2:0] {
      CMD_READ       = 3'h0,
      CMD_WRITE      = 3'h1,
      CMD_LOCK       = 3'h2,
      CMD_PRESENT    = 3'h3,
      CMD_WRITE_PWD  = 3'h4
   } rf_cmd_type;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_EXEC  = 2'b01,
      ST_REPLY = 2'b11
   } guard_state_type;
endpackage

// *** verilog/rf_sector_password_guard.sv ***
// sector access guard: guard bytes, three passwords, rf command checks, i2c access to guard bytes
// assumes the rf front end decodes commands and the i2c front end decodes device select and address
// memory itself sits outside; only access grants, refusals and guard bytes leave this block
// Summary of operation
// - one guard byte per sector, fixed fields
// - guard bytes reset to zero
// - unlocked sector allows read and write
// - locked sector obeys protection code table
// - link bits select no password or one
// - three passwords in separate slots one-three
// - password write stores word, active at once
// - password write needs valid presentation first
// - passwords reset to zero and active
// - lock loads bits four-one, sets lock
// - lock on locked sector gives error
// - match grants rights to linked sectors
// - mismatch revokes all granted rights
// - i2c reads free, writes need i2c password
// - guard bytes at system byte address zero
// - i2c write reinitialises sector rf access state
// - read with option flag returns guard byte
// - sector index is block address over 32
`timescale 1ns/1ps
`default_nettype none
module rf_sector_password_guard #(
   parameter int SECTORS = sector_guard_pkg::SECTOR_COUNT,
   parameter int PWD_W   = sector_guard_pkg::PASSWORD_WIDTH
) (
   input  wire logic                                         clk,
   input  wire logic                                         rst_n,
   // rf command port
   input  wire logic                                         rfCmdValid,
   input  wire sector_guard_pkg::rf_cmd_type                 rfCmd,
   input  wire logic [sector_guard_pkg::BLOCK_ADDR_WIDTH-1:0] rfBlockAddr,
   input  wire logic [1:0]                                   rfSlot,
   input  wire logic [PWD_W-1:0]                             rfData,
   input  wire logic                                         rfOptionFlag,
   output logic                                              rfCmdReady,
   output logic                                              rfDone,
   output logic                                              rfError,
   output logic                                              rfMemRead,
   output logic                                              rfMemWrite,
   output logic                                              rfGuardValid,
   output logic [7:0]                                        rfGuardByte,
   // i2c system area port
   input  wire logic                                         i2cAccess,
   input  wire logic                                         i2cWrite,
   input  wire logic                                         systemAreaSelect,
   input  wire logic [10:0]                                  i2cByteAddr,
   input  wire logic [3:0]                                   i2cByteEn,
   input  wire logic [31:0]                                  i2cWData,
   input  wire logic                                         i2cPasswordOk,
   output logic [31:0]                                       i2cRData,
   output logic                                              i2cAck
);

   // password slots one to three; slot zero is refused
   localparam int NSLOT = 3;

   // per-sector guard bytes and password-holder rights
   logic [7:0]         sectorGuardByte_r [SECTORS];
   logic [SECTORS-1:0] granted_r;
   // password store and which slot is presented
   logic [PWD_W-1:0]   password_r [NSLOT];
   logic [NSLOT-1:0]   presented_r;
   // command latched at the taking edge
   sector_guard_pkg::guard_state_type state_r;
   sector_guard_pkg::rf_cmd_type      cmd_r;
   logic [sector_guard_pkg::BLOCK_ADDR_WIDTH-1:0] addr_r;
   logic [1:0]         slot_r;
   logic [PWD_W-1:0]   data_r;
   logic               opt_r;

   // sector of a block address
   // top two address bits pick one of four sectors
   function automatic logic [1:0] sectorOf(input logic [sector_guard_pkg::BLOCK_ADDR_WIDTH-1:0] a);
      return a[sector_guard_pkg::SECTOR_SHIFT +: 2];
   endfunction

   // read permission of a guard byte given password right
   // 00 and 01 read freely, 10 and 11 need the right
   function automatic logic readOk(input logic [7:0] g, input logic right);
      logic [1:0] p;
      p = g[sector_guard_pkg::PROT_LSB +: 2];
      if (!g[sector_guard_pkg::LOCK_BIT]) begin
         return 1'b1;
      end
      if (p == sector_guard_pkg::PROT_RW_PWD || p == sector_guard_pkg::PROT_RD_PWD) begin
         return right;
      end
      return 1'b1;
   endfunction

   // write permission of a guard byte given password right
   // 01 writes freely, 11 never, 00 and 10 need the right
   function automatic logic writeOk(input logic [7:0] g, input logic right);
      logic [1:0] p;
      p = g[sector_guard_pkg::PROT_LSB +: 2];
      if (!g[sector_guard_pkg::LOCK_BIT]) begin
         return 1'b1;
      end
      case (p)
         sector_guard_pkg::PROT_OPEN:   return 1'b1;
         sector_guard_pkg::PROT_RD_PWD: return 1'b0;
         default:                       return right;
      endcase
   endfunction

   // decode of the latched command's sector and slot
   logic [1:0] curSector;
   logic [7:0] curGuard;
   logic       curRight;
   logic       slotLegal;
   logic       i2cHit;
   logic       i2cWr;
   assign curSector  = sectorOf(addr_r);
   assign curGuard   = sectorGuardByte_r[curSector];
   assign curRight   = granted_r[curSector];
   assign slotLegal  = (slot_r != 2'd0);
   assign i2cHit     = i2cAccess && systemAreaSelect && (i2cByteAddr == sector_guard_pkg::GUARD_BYTES_ADDR);
   assign i2cWr      = i2cHit && i2cWrite && i2cPasswordOk;
   // ready low from the taking edge until the reply has stood
   assign rfCmdReady = (state_r == sector_guard_pkg::ST_IDLE);

   // command capture and sequencing
   // reply is launched at the edge after the taking edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= sector_guard_pkg::ST_IDLE;
         cmd_r   <= sector_guard_pkg::CMD_READ;
         addr_r  <= '0;
         slot_r  <= 2'd0;
         data_r  <= '0;
         opt_r   <= 1'b0;
      end else begin
         case (state_r)
            // a command is looked at only while idle
            sector_guard_pkg::ST_IDLE: begin
               if (rfCmdValid) begin
                  cmd_r   <= rfCmd;
                  addr_r  <= rfBlockAddr;
                  slot_r  <= rfSlot;
                  data_r  <= rfData;
                  opt_r   <= rfOptionFlag;
                  state_r <= sector_guard_pkg::ST_EXEC;
               end
            end
            sector_guard_pkg::ST_EXEC:  state_r <= sector_guard_pkg::ST_REPLY;
            // reply state holds ready low one more cycle
            default:                    state_r <= sector_guard_pkg::ST_IDLE;
         endcase
      end
   end

   // execution decision and reply outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rfDone       <= 1'b0;
         rfError      <= 1'b0;
         rfMemRead    <= 1'b0;
         rfMemWrite   <= 1'b0;
         rfGuardValid <= 1'b0;
         rfGuardByte  <= 8'h00;
      end else begin
         // every reply output except rfGuardByte is a one-cycle pulse
         rfDone       <= 1'b0;
         rfError      <= 1'b0;
         rfMemRead    <= 1'b0;
         rfMemWrite   <= 1'b0;
         rfGuardValid <= 1'b0;
         if (state_r == sector_guard_pkg::ST_EXEC) begin
            rfDone <= 1'b1;
            case (cmd_r)
               sector_guard_pkg::CMD_READ: begin
                  if (readOk(curGuard, curRight)) begin
                     rfMemRead    <= 1'b1;
                     rfGuardValid <= opt_r;
                     rfGuardByte  <= curGuard;
                  end else begin
                     rfError <= 1'b1;
                  end
               end
               sector_guard_pkg::CMD_WRITE: begin
                  if (writeOk(curGuard, curRight)) begin
                     rfMemWrite <= 1'b1;
                  end else begin
                     rfError <= 1'b1;
                  end
               end
               sector_guard_pkg::CMD_LOCK: begin
                  // a lock never opens memory
                  // relock is an error
                  rfError <= curGuard[sector_guard_pkg::LOCK_BIT];
               end
               sector_guard_pkg::CMD_PRESENT: begin
                  rfError <= !slotLegal || (password_r[slot_r - 2'd1] != data_r);
               end
               sector_guard_pkg::CMD_WRITE_PWD: begin
                  rfError <= !slotLegal || !presented_r[slot_r - 2'd1];
               end
               default: rfError <= 1'b1;
            endcase
         end
      end
   end

   // password slots and presentation state
   // a mismatch or slot zero drops every presentation
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NSLOT; i++) begin
            password_r[i] <= PWD_W'(sector_guard_pkg::PASSWORD_RESET);
         end
         presented_r <= '0;
      end else if (state_r == sector_guard_pkg::ST_EXEC && slotLegal) begin
         if (cmd_r == sector_guard_pkg::CMD_PRESENT) begin
            presented_r <= '0;
            if (password_r[slot_r - 2'd1] == data_r) begin
               presented_r[slot_r - 2'd1] <= 1'b1;
            end
         end else if (cmd_r == sector_guard_pkg::CMD_WRITE_PWD && presented_r[slot_r - 2'd1]) begin
            // ignored unless its own slot is presented
            // store, active at once
            password_r[slot_r - 2'd1] <= data_r;
         end
      end else if (state_r == sector_guard_pkg::ST_EXEC && cmd_r == sector_guard_pkg::CMD_PRESENT) begin
         presented_r <= '0;
      end
   end

   // guard bytes and per-sector rights
   // one process per sector so each byte has a single driver
   generate
      for (genvar s = 0; s < SECTORS; s++) begin : g_sector
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               sectorGuardByte_r[s] <= sector_guard_pkg::GUARD_BYTE_RESET;
               granted_r[s]         <= 1'b0;
            end else if (i2cWr && i2cByteEn[s]) begin
               // i2c write wins over a same-cycle rf lock
               // upper bits forced zero
               sectorGuardByte_r[s] <= {3'b000, i2cWData[8*s +: sector_guard_pkg::USED_BITS]};
               granted_r[s]         <= 1'b0;
            end else if (state_r == sector_guard_pkg::ST_EXEC) begin
               // a locked byte is never changed from the rf side
               if (cmd_r == sector_guard_pkg::CMD_LOCK && curSector == 2'(s) &&
                   !curGuard[sector_guard_pkg::LOCK_BIT]) begin
                  // load bits, set lock
                  // protection and link come from data bits four to one
                  sectorGuardByte_r[s] <= {3'b000, data_r[sector_guard_pkg::LINK_LSB +: 2],
                                           data_r[sector_guard_pkg::PROT_LSB +: 2], 1'b1};
               end
               if (cmd_r == sector_guard_pkg::CMD_PRESENT) begin
                  // rights follow the link bits as they stand now
                  // link selects password
                  granted_r[s] <= slotLegal &&
                                  (password_r[slot_r - 2'd1] == data_r) &&
                                  (sectorGuardByte_r[s][sector_guard_pkg::LINK_LSB +: 2] == slot_r) &&
                                  (slot_r != sector_guard_pkg::LINK_NONE);
               end
            end
         end
      end
   endgenerate

   // i2c read data and acknowledge
   // ack only on a hit; a write also needs the i2c password
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         i2cRData <= 32'h0000_0000;
         i2cAck   <= 1'b0;
      end else begin
         i2cAck <= i2cHit && (!i2cWrite || i2cPasswordOk);
         // reads always allowed
         // data are the guard bytes as they stand
         if (i2cHit && !i2cWrite) begin
            for (int k = 0; k < SECTORS; k++) begin
               i2cRData[8*k +: 8] <= sectorGuardByte_r[k];
            end
         end
      end
   end

endmodule
`default_nettype wire

// *** tb/sector_guard_assertions.sv ***
// checker for guard port timing, answer masking and i2c gating
// assumes the guard's clk and async active-low rst_n
`timescale 1ns/1ps
`default_nettype none
module sector_guard_assertions (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        rfCmdValid,
   input wire logic        rfCmdReady,
   input wire logic        rfDone,
   input wire logic        rfError,
   input wire logic        rfMemRead,
   input wire logic        rfMemWrite,
   input wire logic        rfGuardValid,
   input wire logic [7:0]  rfGuardByte,
   input wire logic        i2cAccess,
   input wire logic        i2cWrite,
   input wire logic        systemAreaSelect,
   input wire logic [10:0] i2cByteAddr,
   input wire logic        i2cPasswordOk,
   input wire logic [31:0] i2cRData,
   input wire logic        i2cAck
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // rf answer timing and pulse shape
   a_answer_delay: assert property (rfCmdValid && rfCmdReady |=> !rfCmdReady ##1 rfDone)
      else $error("rf answer not two cycles after take");
   a_done_single: assert property (rfDone |=> !rfDone)
      else $error("rf done longer than one cycle");
   a_error_with_done: assert property (rfError |-> rfDone)
      else $error("rf error without done");
   a_denied_no_mem: assert property (rfError |-> !rfMemRead && !rfMemWrite)
      else $error("memory access granted with error");
   a_guard_read_only: assert property (rfGuardValid |-> rfMemRead && rfGuardByte[7:5] == 3'h0)
      else $error("guard byte without read or with upper bits");
   // i2c side gating and padding
   a_pad_zero: assert property ({i2cRData[31:29], i2cRData[23:21], i2cRData[15:13], i2cRData[7:5]} == 12'h000)
      else $error("i2c guard byte upper bits not zero");
   a_write_gated: assert property (i2cAccess && i2cWrite && !i2cPasswordOk |=> !i2cAck)
      else $error("i2c write acked without password");
   a_read_free: assert property (i2cAccess && !i2cWrite && systemAreaSelect && i2cByteAddr == 11'h000 |=> i2cAck)
      else $error("i2c read not acked");
   a_ack_cause: assert property (i2cAck |-> $past(i2cAccess) && $past(systemAreaSelect))
      else $error("i2c ack without selected access");
endmodule
bind rf_sector_password_guard sector_guard_assertions chk (.clk, .rst_n, .rfCmdValid, .rfCmdReady, .rfDone,
   .rfError, .rfMemRead, .rfMemWrite, .rfGuardValid, .rfGuardByte, .i2cAccess, .i2cWrite,
   .systemAreaSelect, .i2cByteAddr, .i2cPasswordOk, .i2cRData, .i2cAck);
`default_nettype wire

// *** tb/guard_reader_model.sv ***
// rf reader model: offers one command at a time, holds it until taken
// assumes a shared clock; caller samples the answer when issue returns
`timescale 1ns/1ps
`default_nettype none
module guard_reader_model (
   input  wire logic                         clk,
   input  wire logic                         rfCmdReady,
   output logic                              rfCmdValid,
   output var sector_guard_pkg::rf_cmd_type  rfCmd,
   output logic [6:0]                        rfBlockAddr,
   output logic [1:0]                        rfSlot,
   output logic [31:0]                       rfData,
   output logic                              rfOptionFlag
);
   // idle lines at time zero
   initial begin
      rfCmdValid = 1'b0;
      rfCmd = sector_guard_pkg::CMD_READ;
      rfBlockAddr = 7'h00;
      rfSlot = 2'h0;
      rfData = 32'h0000_0000;
      rfOptionFlag = 1'b0;
   end
   // request held across the taking edge; returns while the answer stands
   task automatic issue(input sector_guard_pkg::rf_cmd_type c, input logic [6:0] a, input logic [1:0] s,
                        input logic [31:0] d, input logic o);
      while (rfCmdReady !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      rfCmdValid = 1'b1;
      rfCmd = c;
      rfBlockAddr = a;
      rfSlot = s;
      rfData = d;
      rfOptionFlag = o;
      @(posedge clk);
      #1 rfCmdValid = 1'b0;
      // released data and address lines must not keep the last value
      rfData = ~d;
      rfBlockAddr = ~a;
      // answer is launched at the next edge and stands one cycle
      @(posedge clk);
      #1;
   endtask
endmodule
`default_nettype wire

// *** tb/rf_sector_password_guard_bench.sv ***
// self-checking bench: rf commands through the reader model, i2c driven here
// assumes the guard package and reader model are compiled first
`timescale 1ns/1ps
`default_nettype none
module rf_sector_password_guard_bench;
   localparam sector_guard_pkg::rf_cmd_type RD = sector_guard_pkg::CMD_READ;
   localparam sector_guard_pkg::rf_cmd_type WR = sector_guard_pkg::CMD_WRITE;
   localparam sector_guard_pkg::rf_cmd_type LK = sector_guard_pkg::CMD_LOCK;
   localparam sector_guard_pkg::rf_cmd_type PR = sector_guard_pkg::CMD_PRESENT;
   localparam sector_guard_pkg::rf_cmd_type WP = sector_guard_pkg::CMD_WRITE_PWD;
   logic clk, rst_n, rfCmdValid, rfOptionFlag, rfCmdReady, rfDone, rfError, rfMemRead, rfMemWrite;
   logic rfGuardValid, i2cAccess, i2cWrite, systemAreaSelect, i2cPasswordOk, i2cAck;
   logic [6:0] rfBlockAddr;
   logic [1:0] rfSlot;
   logic [7:0] rfGuardByte;
   logic [10:0] i2cByteAddr;
   logic [3:0] i2cByteEn;
   logic [31:0] rfData, i2cWData, i2cRData;
   sector_guard_pkg::rf_cmd_type rfCmd;
   int fails = 0;
   int checksDone = 0;
   int cycles = 0;
   rf_sector_password_guard dut (.clk, .rst_n, .rfCmdValid, .rfCmd, .rfBlockAddr, .rfSlot, .rfData,
      .rfOptionFlag, .rfCmdReady, .rfDone, .rfError, .rfMemRead, .rfMemWrite, .rfGuardValid, .rfGuardByte,
      .i2cAccess, .i2cWrite, .systemAreaSelect, .i2cByteAddr, .i2cByteEn, .i2cWData, .i2cPasswordOk,
      .i2cRData, .i2cAck);
   guard_reader_model reader (.clk, .rfCmdReady, .rfCmdValid, .rfCmd, .rfBlockAddr, .rfSlot, .rfData,
      .rfOptionFlag);
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one rf command; compares done, error, read, write, guard valid
   task automatic rf(input sector_guard_pkg::rf_cmd_type c, input logic [6:0] a, input logic [1:0] s,
                     input logic [31:0] d, input logic [4:0] exp);
      reader.issue(c, a, s, d, c == RD);
      chk("rf result", {27'h0, exp}, {27'h0, rfDone, rfError, rfMemRead, rfMemWrite, rfGuardValid});
   endtask
   task automatic rdChk(input logic [6:0] a, input logic ok, input logic [7:0] gb);
      rf(RD, a, 2'h0, 32'h0, {1'b1, !ok, ok, 1'b0, ok});
      if (ok) chk("guard byte", {24'h0, gb}, {24'h0, rfGuardByte});
   endtask
   task automatic wrChk(input logic [6:0] a, input logic ok);
      rf(WR, a, 2'h0, 32'h0, {1'b1, !ok, 1'b0, ok, 1'b0});
   endtask
   // one i2c access at the guard byte word
   task automatic i2c(input logic w, input logic [3:0] be, input logic [31:0] d, input logic ok, input logic ack);
      i2cAccess = 1'b1;
      i2cWrite = w;
      i2cByteEn = be;
      i2cWData = d;
      i2cPasswordOk = ok;
      @(posedge clk);
      #1 i2cAccess = 1'b0;
      i2cWData = ~d;
      // ack stands for the cycle after the strobe edge
      chk("i2c ack", {31'h0, ack}, {31'h0, i2cAck});
      @(posedge clk);
      #1;
   endtask
   // power-up state: zero bytes, zero passwords active, sectors open
   task automatic t_reset();
      i2c(1'b0, 4'h0, 32'h0, 1'b0, 1'b1);
      chk("guard bytes", 32'h0000_0000, i2cRData);
      rf(PR, 7'h00, 2'h3, 32'h0, 5'b10000);
      wrChk(7'h1F, 1'b1);
      rdChk(7'h1F, 1'b1, 8'h00);
      reader.issue(RD, 7'h1F, 2'h0, 32'h0, 1'b0);
      chk("rf no option", 32'h0000_0014, {27'h0, rfDone, rfError, rfMemRead, rfMemWrite, rfGuardValid});
      $display("test reset done");
   endtask
   // every protection code on sector 1, with and without password
   task automatic t_codes();
      for (int p = 0; p < 4; p++) begin
         i2c(1'b1, 4'b0010, 32'h0, 1'b1, 1'b1);
         rf(LK, 7'h3F, 2'h1, {27'h0, 2'b01, p[1:0], 1'b0}, 5'b10000);
         rf(LK, 7'h20, 2'h1, 32'h0, 5'b11000);
         rf(PR, 7'h00, 2'h1, 32'h1, 5'b11000);
         rdChk(7'h3F, p < 2, {5'b00001, p[1:0], 1'b1});
         wrChk(7'h3F, p == 1);
         rf(PR, 7'h00, 2'h1, 32'h0, 5'b10000);
         rdChk(7'h20, 1'b1, {5'b00001, p[1:0], 1'b1});
         wrChk(7'h20, p != 3);
      end
      wrChk(7'h1F, 1'b1);
      i2c(1'b0, 4'h0, 32'h0, 1'b0, 1'b1);
      chk("guard bytes", 32'h0000_0F00, i2cRData);
      $display("test codes done");
   endtask
   // password change needs that slot presented; new value live at once
   task automatic t_pwd();
      rf(WP, 7'h00, 2'h2, 32'hA5A5_0001, 5'b11000);
      rf(PR, 7'h00, 2'h2, 32'h0, 5'b10000);
      rf(WP, 7'h00, 2'h2, 32'hA5A5_0001, 5'b10000);
      rf(PR, 7'h00, 2'h2, 32'h0, 5'b11000);
      rf(PR, 7'h00, 2'h2, 32'hA5A5_0001, 5'b10000);
      rdChk(7'h3F, 1'b0, 8'h00);
      rf(PR, 7'h00, 2'h0, 32'h0, 5'b11000);
      $display("test password done");
   endtask
   // i2c writes gated by password, fields masked, rf access follows
   task automatic t_i2c();
      i2c(1'b1, 4'b1000, 32'hFF00_0000, 1'b0, 1'b0);
      i2c(1'b1, 4'b1000, 32'hFF00_0000, 1'b1, 1'b1);
      // user area select and a wrong address must miss the guard bytes
      systemAreaSelect = 1'b0;
      i2c(1'b0, 4'h0, 32'h0, 1'b0, 1'b0);
      systemAreaSelect = 1'b1;
      i2cByteAddr = 11'h004;
      i2c(1'b1, 4'b0001, 32'h0000_001F, 1'b1, 1'b0);
      i2cByteAddr = 11'h000;
      i2c(1'b0, 4'h0, 32'h0, 1'b0, 1'b1);
      chk("guard bytes", 32'h1F00_0F00, i2cRData);
      rdChk(7'h7F, 1'b0, 8'h00);
      $display("test i2c done");
   endtask
   initial begin
      rst_n = 1'b0;
      i2cAccess = 1'b0;
      i2cWrite = 1'b0;
      // reach the guard bytes in the system area
      systemAreaSelect = 1'b1;
      i2cByteAddr = 11'h000;
      i2cByteEn = 4'h0;
      i2cWData = 32'h0000_0000;
      i2cPasswordOk = 1'b0;
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      t_reset();
      t_codes();
      t_pwd();
      t_i2c();
      close_out();
   end
endmodule
`default_nettype wire
